// File: abps_serial_out.v
// absolute position serial output: sample buffer and link slave
// assumes link_clk comes from the master, unrelated to clk
//
// Function
// - after reset the block starts in position output mode, not setup mode
// - two modes: position output, and setup reusing data as tx, clock as rx
// - point to point; master drives clock 0.1-5 MHz, block returns data
// - in SSI with test option fitted, error bit follows position: 0 good, 1 fault
// - without test option no extra error bit is sent in SSI
// - BiSS-C: unidirectional slave shifting data on the master clock
// - held position refreshes at 35 kHz, optionally 375 kHz
// - count direction selectable between clockwise and counter-clockwise
// - BiSS-C frame opens with data low one clock as acknowledge
`timescale 1ns/10ps
`include "abps_regs.vh"

// small synchronous fifo, registered ready and valid
module abps_fifo #(
  parameter W     = 19,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire         clk,
  input  wire         reset_n,
  input  wire         clk_en,
  input  wire [W-1:0] in_data,
  input  wire         in_valid,
  output reg          in_ready_q,
  output wire [W-1:0] out_data,
  output reg          out_valid_q,
  input  wire         out_ready
);
  reg [W-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_q;
  reg [AW-1:0] rd_ptr_q;
  reg [AW:0]   count_q;
  reg [AW:0]   count_d;
  wire         push;
  wire         pop;

  assign push = in_valid & in_ready_q;
  assign pop  = out_ready & out_valid_q;
  assign out_data = mem[rd_ptr_q];

  // occupancy after this cycle
  always @* begin
    count_d = count_q;
    if (push & ~pop) begin
      count_d = count_q + 1'b1;
    end else if (pop & ~push) begin
      count_d = count_q - 1'b1;
    end
  end

  // storage has no reset; valid flags guard it
  always @(posedge clk) begin
    if (clk_en & push) begin
      mem[wr_ptr_q] <= in_data;
    end
  end

  // pointers and flags, ready taken from next count
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_q    <= {AW{1'b0}};
      rd_ptr_q    <= {AW{1'b0}};
      count_q     <= {(AW+1){1'b0}};
      in_ready_q  <= 1'b0;
      out_valid_q <= 1'b0;
    end else if (clk_en) begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      count_q     <= count_d;
      // full at DEPTH words, so a push never lands on an unread slot
      in_ready_q  <= (count_d != DEPTH[AW:0]);
      out_valid_q <= (count_d != {(AW+1){1'b0}});
    end
  end
endmodule // abps_fifo

module abps_serial_out (
  input  wire                   clk,
  input  wire                   reset_n,
  input  wire                   clk_en,
  input  wire                   link_clk,
  input  wire [`ABPS_POS_W-1:0] pos_data,
  input  wire                   pos_valid,
  output wire                   pos_ready,
  input  wire                   biss_sel,
  input  wire                   bit_fitted,
  input  wire                   bit_error,
  input  wire                   dir_ccw,
  input  wire                   fast_rate,
  input  wire                   setup_req,
  input  wire                   setup_tx,
  output reg                    setup_rx_q,
  output reg                    data_out_q,
  output reg                    setup_mode_q,
  output reg                    frame_active_q
);
  // one-hot link states
  localparam ST_IDLE  = 3'b001;
  localparam ST_SHIFT = 3'b010;
  localparam ST_SETUP = 3'b100;

  // timing limits, cut to the counter width on purpose
  localparam MONO_LIM = `ABPS_MONO_CYC - 1;
  localparam UPD_LIM  = `ABPS_UPD_CYC - 1;
  localparam FAST_LIM = `ABPS_UPD_FAST_CYC - 1;
  localparam [`ABPS_CNT_W-1:0] MONO_LAST = MONO_LIM[`ABPS_CNT_W-1:0];
  localparam [`ABPS_CNT_W-1:0] UPD_LAST  = UPD_LIM[`ABPS_CNT_W-1:0];
  localparam [`ABPS_CNT_W-1:0] FAST_LAST = FAST_LIM[`ABPS_CNT_W-1:0];
  localparam [`ABPS_CRC_W-1:0] CRC_POLY  = `ABPS_CRC_POLY;

  reg [2:0]             state_q;
  reg                   lc_s1_q;
  reg                   lc_s2_q;
  reg                   lc_prev_q;
  reg [`ABPS_CNT_W-1:0] mono_q;
  reg [`ABPS_CNT_W-1:0] upd_q;
  reg [`ABPS_POS_W-1:0] pos_q;
  reg [`ABPS_FRM_W-1:0] frame_q;
  reg [`ABPS_FRM_W-1:0] frame_d;
  wire                  lc_fall;
  wire                  lc_rise;
  wire                  upd_tick;
  wire [`ABPS_CNT_W-1:0] upd_last;
  wire [`ABPS_POS_W-1:0] fifo_data;
  wire                  fifo_valid;
  wire [`ABPS_POS_W-1:0] tx_pos;
  wire                  n_err;
  wire [`ABPS_CRC_W-1:0] crc;

  // serial crc over position and status bits, msb first
  function [`ABPS_CRC_W-1:0] abps_crc6;
    input [`ABPS_POS_W+1:0] d;
    integer i;
    reg     fb;
    reg [`ABPS_CRC_W-1:0] c;
    begin
      c = {`ABPS_CRC_W{1'b0}};
      for (i = `ABPS_POS_W + 1; i >= 0; i = i - 1) begin
        fb = c[`ABPS_CRC_W-1] ^ d[i];
        c  = {c[`ABPS_CRC_W-2:0], 1'b0} ^ (fb ? CRC_POLY : {`ABPS_CRC_W{1'b0}});
      end
      abps_crc6 = c;
    end
  endfunction

  // samples from the sensing core wait here until the refresh tick
  abps_fifo #(
    .W     (`ABPS_POS_W),
    .DEPTH (`ABPS_FIFO_DEPTH),
    .AW    (`ABPS_FIFO_AW)
  ) u_fifo (
    .clk         (clk),
    .reset_n     (reset_n),
    .clk_en      (clk_en),
    .in_data     (pos_data),
    .in_valid    (pos_valid),
    .in_ready_q  (pos_ready),
    .out_data    (fifo_data),
    .out_valid_q (fifo_valid),
    .out_ready   (upd_tick)
  );

  // refresh divider, rate chosen live; a switch to the fast rate
  // with the count already past its limit ends the period at once
  // rather than running the counter round through all its codes
  assign upd_last = fast_rate ? FAST_LAST : UPD_LAST;
  assign upd_tick = (upd_q >= upd_last);

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      upd_q <= {`ABPS_CNT_W{1'b0}};
      pos_q <= `ABPS_POS_RST;
    end else if (clk_en) begin
      if (upd_tick) begin
        upd_q <= {`ABPS_CNT_W{1'b0}};
      end else begin
        upd_q <= upd_q + 1'b1;
      end
      // an empty buffer leaves the last position standing
      if (upd_tick & fifo_valid) begin
        pos_q <= fifo_data;
      end
    end
  end

  // counter-clockwise sense sends the negated count modulo a turn
  assign tx_pos = dir_ccw ? (~pos_q + 1'b1) : pos_q;
  assign n_err  = ~(bit_fitted & bit_error);
  assign crc    = abps_crc6({tx_pos, n_err, 1'b1});

  // frame image, msb leaves first; tail fills with zeros
  always @* begin
    frame_d = {`ABPS_FRM_W{1'b0}};
    if (biss_sel) begin
      // ack low, start high, cds low, data, status, inverted crc
      frame_d = {1'b0, 1'b1, 1'b0, tx_pos, n_err, 1'b1, ~crc};
    end else if (bit_fitted) begin
      // error bit follows the word; 1 flags a fault
      frame_d[`ABPS_FRM_W-1 -: `ABPS_POS_W+1] = {tx_pos, bit_error};
    end else begin
      // no error slot; the master sees the zero tail after the word
      frame_d[`ABPS_FRM_W-1 -: `ABPS_POS_W] = tx_pos;
    end
  end

  // two flops before anything looks at the master clock
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      // idle level of the pin, so no false fall follows reset
      lc_s1_q   <= 1'b1;
      lc_s2_q   <= 1'b1;
      lc_prev_q <= 1'b1;
    end else if (clk_en) begin
      lc_s1_q   <= link_clk;
      lc_s2_q   <= lc_s1_q;
      lc_prev_q <= lc_s2_q;
    end
  end

  assign lc_fall = lc_prev_q & ~lc_s2_q;
  assign lc_rise = ~lc_prev_q & lc_s2_q;

  // link slave; edges restart the monoflop, its expiry ends the frame
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q        <= ST_IDLE;
      mono_q         <= {`ABPS_CNT_W{1'b0}};
      frame_q        <= {`ABPS_FRM_W{1'b0}};
      data_out_q     <= `ABPS_DATA_IDLE;
      setup_rx_q     <= 1'b1;
      setup_mode_q   <= 1'b0;
      frame_active_q <= 1'b0;
    end else if (clk_en) begin
      case (state_q)
        ST_IDLE: begin
          data_out_q <= `ABPS_DATA_IDLE;
          mono_q     <= {`ABPS_CNT_W{1'b0}};
          // mode changes only between frames so no frame is cut
          if (setup_req) begin
            state_q      <= ST_SETUP;
            setup_mode_q <= 1'b1;
          end else if (lc_fall) begin
            frame_q        <= frame_d;
            state_q        <= ST_SHIFT;
            frame_active_q <= 1'b1;
          end
        end
        ST_SHIFT: begin
          // each rise launches one bit; the master reads it on a later rise
          if (lc_rise) begin
            data_out_q <= frame_q[`ABPS_FRM_W-1];
            frame_q    <= {frame_q[`ABPS_FRM_W-2:0], 1'b0};
            mono_q     <= {`ABPS_CNT_W{1'b0}};
          // falls only rearm the monoflop; no second latch in a frame
          end else if (lc_fall) begin
            mono_q <= {`ABPS_CNT_W{1'b0}};
          end else if (mono_q == MONO_LAST) begin
            // master paused long enough; data back high
            data_out_q     <= `ABPS_DATA_IDLE;
            state_q        <= ST_IDLE;
            frame_active_q <= 1'b0;
          end else begin
            mono_q <= mono_q + 1'b1;
          end
        end
        ST_SETUP: begin
          // data pin carries setup tx, clock pin feeds setup rx
          data_out_q <= setup_tx;
          setup_rx_q <= lc_s2_q;
          if (!setup_req) begin
            state_q      <= ST_IDLE;
            setup_mode_q <= 1'b0;
            data_out_q   <= `ABPS_DATA_IDLE;
            setup_rx_q   <= 1'b1;
          end
        end
        default: begin
          // an illegal code falls back to idle with the line released
          state_q    <= ST_IDLE;
          data_out_q <= `ABPS_DATA_IDLE;
        end
      endcase
    end
  end

  // spacing of requests is the master's duty; the monoflop
  // expiring first keeps a too-early request from being taken
  // as a new frame while the tail is still low
endmodule // abps_serial_out

// File: abps_regs.vh
// constants for the absolute position serial output block
// assumes a 20 MHz core clock and a 19-bit position word
`ifndef ABPS_REGS_VH
`define ABPS_REGS_VH

// core clock rate
`define ABPS_CLK_MHZ      20
`define ABPS_CLK_HZ       20000000

// position word and frame widths
`define ABPS_POS_W        19
`define ABPS_FRM_W        30
`define ABPS_CRC_W        6
`define ABPS_CRC_POLY     6'h03

// monoflop interval in ns, cycles rounded down, no lower bound applied
`define ABPS_MONO_NS      25000
`define ABPS_MONO_CYC     ((`ABPS_MONO_NS * `ABPS_CLK_MHZ) / 1000)

// position refresh rates and their cycle counts
`define ABPS_UPD_HZ       35000
`define ABPS_UPD_FAST_HZ  375000
`define ABPS_UPD_CYC      (`ABPS_CLK_HZ / `ABPS_UPD_HZ)
`define ABPS_UPD_FAST_CYC (`ABPS_CLK_HZ / `ABPS_UPD_FAST_HZ)
`define ABPS_CNT_W        10

// sample buffer
`define ABPS_FIFO_DEPTH   16
`define ABPS_FIFO_AW      4

// reset values
`define ABPS_DATA_IDLE    1'b1
`define ABPS_POS_RST      19'h00000

`endif

// File: abps_monitor.sv
// checker on the serial output ports
// assumes one clk domain; bound from tb_top
`timescale 1ns/10ps
module abps_monitor (
  input wire clk,
  input wire reset_n,
  input wire link_clk,
  input wire pos_valid,
  input wire pos_ready,
  input wire biss_sel,
  input wire setup_req,
  input wire setup_tx,
  input wire setup_rx_q,
  input wire data_out_q,
  input wire setup_mode_q,
  input wire frame_active_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  reg       link_q;
  reg [9:0] quiet_q;
  // cycles since the pin moved; saturates so it never wraps back to 0
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      link_q  <= 1'h1;
      quiet_q <= 10'h0;
    end else begin
      link_q  <= link_clk;
      quiet_q <= (link_q != link_clk) ? 10'h0 : quiet_q + {9'h0, quiet_q != 10'h3FF};
    end
  end
  sequence s_biss_start;
    $rose(frame_active_q) && biss_sel;
  endsequence
  a_stay_pos: assert property (!setup_req && !setup_mode_q |=> !setup_mode_q)
    else $error("setup mode entered unasked");
  a_setup_enter: assert property (setup_req && !frame_active_q |=> setup_mode_q)
    else $error("setup request ignored");
  a_setup_echo: assert property (setup_mode_q && $past(setup_mode_q) |-> data_out_q == $past(setup_tx))
    else $error("setup tx not echoed");
  a_rx_idle: assert property (!setup_mode_q && !$past(setup_mode_q) |-> setup_rx_q)
    else $error("setup rx low outside setup");
  a_idle_high: assert property (!frame_active_q && !setup_mode_q && !$past(setup_mode_q)
    |-> data_out_q or ##1 frame_active_q)
    else $error("data low while idle");
  a_frame_quiet: assert property (quiet_q > 10'h208 |-> !frame_active_q)
    else $error("frame outlived monoflop");
  a_ack_low: assert property (s_biss_start |-> ##[0:20] !data_out_q)
    else $error("no acknowledge low");
  a_ready_fall: assert property ($fell(pos_ready) |-> $past(pos_valid) || $past(pos_valid, 2))
    else $error("ready fell without push");
endmodule // abps_monitor

// File: abps_link_master.sv
// link master model: idle-high clock, 400 ns period
// assumes the device answers within one link period
`timescale 1ns/10ps
module abps_link_master (
  output reg  link_clk,
  input  wire data_in
);
  reg [31:0] rx_q;
  initial link_clk = 1'h1;
  // each bit is taken at the rise after the one that launched it
  task automatic xfer(input int n);
    #7;
    rx_q     = 32'h0;
    link_clk = 1'h0;
    for (int i = 0; i <= n; i++) begin
      #200;
      if (i > 0) rx_q = {rx_q[30:0], data_in};
      link_clk = 1'h1;
      if (i < n) begin
        #200;
        link_clk = 1'h0;
      end
    end
    #27000;
  endtask
  // setup mode reuses the clock pair as a plain receive line
  task set_clk(input reg v);
    link_clk = v;
  endtask
endmodule // abps_link_master

// File: tb_top.sv
// bench: random and corner frames, buffer fill, setup mode
// assumes the master model and checker are compiled first
`timescale 1ns/10ps
module tb_top;
  reg        clk = 1'h0;
  reg        reset_n = 1'h0;
  reg [18:0] pos_data = 19'h0;
  reg        pos_valid = 1'h0;
  reg        biss_sel = 1'h0;
  reg        bit_fitted = 1'h0;
  reg        bit_error = 1'h0;
  reg        dir_ccw = 1'h0;
  reg        fast_rate = 1'h1;
  reg        setup_req = 1'h0;
  reg        setup_tx = 1'h1;
  wire       link_clk, pos_ready, setup_rx_q, data_out_q, setup_mode_q, frame_active_q;
  int        error_cnt = 0;
  int        tests_run = 0;
  int        seed = 32'hc57dbefe;
  int        n, k;
  reg [18:0] p, last;
  always #25 clk = ~clk;
  abps_serial_out u_dut (.clk(clk), .reset_n(reset_n), .clk_en(1'h1), .link_clk(link_clk),
    .pos_data(pos_data), .pos_valid(pos_valid), .pos_ready(pos_ready), .biss_sel(biss_sel),
    .bit_fitted(bit_fitted), .bit_error(bit_error), .dir_ccw(dir_ccw), .fast_rate(fast_rate),
    .setup_req(setup_req), .setup_tx(setup_tx), .setup_rx_q(setup_rx_q),
    .data_out_q(data_out_q), .setup_mode_q(setup_mode_q), .frame_active_q(frame_active_q));
  abps_link_master u_mst (.link_clk(link_clk), .data_in(data_out_q));
  task chk(input reg [31:0] got, input reg [31:0] want);
    tests_run++;
    if (got !== want) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task push(input reg [18:0] d);
    @(negedge clk);
    pos_data  = d;
    pos_valid = 1'h1;
    @(negedge clk);
    pos_valid = 1'h0;
  endtask
  function automatic [5:0] crc6(input [20:0] d);
    reg [5:0] c;
    c = 6'h0;
    for (int i = 20; i >= 0; i--) c = {c[4:0], 1'h0} ^ ((c[5] ^ d[i]) ? 6'h03 : 6'h00);
    return ~c;
  endfunction
  // whole frame as the master should see it, first bit in the top used slot
  function automatic [31:0] frame_exp(input [18:0] d);
    reg [18:0] w;
    reg        ne;
    w  = dir_ccw ? ~d + 19'h1 : d;
    ne = ~(bit_fitted & bit_error);
    if (biss_sel) return {3'h2, w, ne, 1'h1, crc6({w, ne, 1'h1})};
    return {w, bit_fitted & bit_error};
  endfunction
  task frame(input reg [18:0] d);
    u_mst.xfer(biss_sel ? 30 : 20);
    chk(u_mst.rx_q, frame_exp(d));
    chk({data_out_q, frame_active_q}, 2'h2);
  endtask
  initial begin
    repeat (6) @(negedge clk);
    reset_n = 1'h1;
    @(negedge clk);
    chk({setup_mode_q, data_out_q}, 2'h1);
    // corners first: all zeros, all ones, then random words; modes follow the loop count bits
    for (k = 0; k < 12; k++) begin
      p          = (k < 2) ? {19{k[0]}} : $random(seed);
      biss_sel   = k[0];
      bit_fitted = k[1];
      dir_ccw    = k[2];
      bit_error  = $random(seed);
      push(~p);
      push(p);
      repeat (120) @(negedge clk);
      frame(p);
      $display("frame test %0d done", k);
    end
    // fill at the slow rate until refused, then drain fast
    fast_rate = 1'h0;
    n = 0;
    repeat (20) begin
      @(negedge clk);
      pos_data  = $random(seed);
      pos_valid = 1'h1;
      if (pos_ready === 1'h1) begin
        n++;
        last = pos_data;
      end
    end
    @(negedge clk);
    pos_valid = 1'h0;
    fast_rate = 1'h1;
    chk((n == 16) || (n == 17), 32'h1);
    repeat (1000) @(negedge clk);
    chk(pos_ready, 32'h1);
    frame(last);
    $display("buffer test done");
    setup_req = 1'h1;
    setup_tx  = 1'h0;
    repeat (3) @(negedge clk);
    chk({setup_mode_q, data_out_q}, 2'h2);
    u_mst.set_clk(1'h0);
    repeat (4) @(negedge clk);
    chk(setup_rx_q, 32'h0);
    u_mst.set_clk(1'h1);
    repeat (4) @(negedge clk);
    setup_req = 1'h0;
    repeat (3) @(negedge clk);
    chk({setup_mode_q, data_out_q, setup_rx_q}, 3'h3);
    $display("setup test done");
    conclude;
  end
  initial begin
    #3000000;
    error_cnt++;
    conclude;
  end
endmodule // tb_top
bind abps_serial_out abps_monitor u_mon (.clk(clk), .reset_n(reset_n), .link_clk(link_clk),
  .pos_valid(pos_valid), .pos_ready(pos_ready), .biss_sel(biss_sel), .setup_req(setup_req),
  .setup_tx(setup_tx), .setup_rx_q(setup_rx_q), .data_out_q(data_out_q),
  .setup_mode_q(setup_mode_q), .frame_active_q(frame_active_q));
